//--- rtl/i2c_cmd_pkg.sv
/*
  Constants and carrier types for the I2C host command and burst port.
  Assumes one 100 MHz core clock and an external byte-wide memory port.
*/
package i2c_cmd_pkg;
  localparam logic [6:0] DEV_ADDR7     = 7'h71;
  localparam logic [7:0] REG_COUNT_LO  = 8'h08;
  localparam logic [7:0] REG_COUNT_HI  = 8'h09;
  localparam logic [7:0] REG_DL_SETUP  = 8'h0F;
  localparam logic [7:0] REG_HOST_SEL  = 8'h12;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [7:0] DL_RESET      = 8'h00;
  localparam logic [7:0] HOST_RESET    = 8'h00;
  localparam int BIT_DATA_ONLY         = 7;
  localparam int TGT_LSB               = 5;
  localparam int BIT_WRITE             = 3;
  localparam int LEN_LSB               = 1;
  localparam int BIT_ALEN              = 0;
  localparam logic [1:0] TGT_INSTR     = 2'h0;
  localparam logic [1:0] TGT_DATA      = 2'h1;
  localparam logic [1:0] TGT_REG       = 2'h2;
  localparam logic [1:0] LEN_ONE       = 2'h0;
  localparam logic [1:0] LEN_TWO       = 2'h1;
  localparam logic [1:0] LEN_FOUR      = 2'h2;
  localparam logic [1:0] ADDR_LAST     = 2'h2;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       addr_w;
    logic       rx_valid;
    logic       tx_next;
    logic [7:0] rx_data;
  } link_evt_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        data_mem;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;
endpackage

//--- rtl/i2c_host_command_burst_port.sv
/*
  Command decoder behind the I2C slave port: memory and register access with
  byte-counted bursts. Assumes a memory that returns read data one cycle
  after a read request and accepts writes in the request cycle.
*/
`timescale 1ns/10ps
module i2c_host_command_burst_port (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_n_o,
  output i2c_cmd_pkg::mem_req_t       mem_o,
  input  wire logic [7:0]             mem_rdata_i,
  output logic [7:0]                  host_port_select_o,
  output logic [7:0]                  download_setup_o,
  output logic                        burst_active_o
);
  typedef enum {S_CMD, S_ADDR, S_DATA, S_BURST_W} dec_state_t;
  dec_state_t state;
  i2c_cmd_pkg::link_evt_t evt;
  logic [1:0]  tgt, acnt;
  logic        wr, alen3, ptr_data, burst_wr, burst_rd, rd_reg, fetch_pend;
  logic [2:0]  dleft;
  logic [23:0] addr, ptr, next_addr;
  logic [7:0]  reg_addr, tx_byte, b;
  logic [15:0] burst_byte_count;
  logic [7:0]  download_setup, host_port_select;

  function automatic logic [2:0] data_bytes(input logic [1:0] code);
    case (code)
      i2c_cmd_pkg::LEN_ONE:  data_bytes = 3'h1;
      i2c_cmd_pkg::LEN_TWO:  data_bytes = 3'h2;
      i2c_cmd_pkg::LEN_FOUR: data_bytes = 3'h4;
      default:               data_bytes = 3'h0;
    endcase
  endfunction

  function automatic logic is_mem(input logic [1:0] t);
    is_mem = (t == i2c_cmd_pkg::TGT_INSTR) || (t == i2c_cmd_pkg::TGT_DATA);
  endfunction

  function automatic logic [7:0] reg_value(input logic [7:0] a, input logic [15:0] c,
                                           input logic [7:0] d, input logic [7:0] h);
    case (a)
      i2c_cmd_pkg::REG_COUNT_LO: reg_value = c[7:0];
      i2c_cmd_pkg::REG_COUNT_HI: reg_value = c[15:8];
      i2c_cmd_pkg::REG_DL_SETUP: reg_value = d;
      i2c_cmd_pkg::REG_HOST_SEL: reg_value = h;
      default:                   reg_value = 8'h00;
    endcase
  endfunction

  i2c_slave_link u_link (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .tx_data_i  (tx_byte),
    .evt_o      (evt),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o)
  );

  assign b                  = evt.rx_data;
  assign next_addr          = {b, addr[23:8]};
  assign host_port_select_o = host_port_select;
  assign download_setup_o   = download_setup;
  assign burst_active_o     = burst_wr | burst_rd;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state            <= S_CMD;
      tgt              <= i2c_cmd_pkg::TGT_INSTR;
      wr               <= 1'b0;
      alen3            <= 1'b0;
      dleft            <= 3'h0;
      acnt             <= 2'h0;
      addr             <= 24'h000000;
      ptr              <= 24'h000000;
      ptr_data         <= 1'b0;
      reg_addr         <= 8'h00;
      burst_wr         <= 1'b0;
      burst_rd         <= 1'b0;
      rd_reg           <= 1'b0;
      burst_byte_count <= i2c_cmd_pkg::COUNT_RESET;
      download_setup   <= i2c_cmd_pkg::DL_RESET;
      host_port_select <= i2c_cmd_pkg::HOST_RESET;
      mem_o            <= '0;
    end else begin
      mem_o.req <= 1'b0;
      if (evt.addr_w) begin
        // armed burst frame has no command byte
        state <= burst_wr ? S_BURST_W : S_CMD;
      end else if (evt.rx_valid) begin
        case (state)
          S_CMD: begin
            tgt   <= b[i2c_cmd_pkg::TGT_LSB +: 2];
            wr    <= b[i2c_cmd_pkg::BIT_WRITE];
            alen3 <= b[i2c_cmd_pkg::BIT_ALEN];
            dleft <= data_bytes(b[i2c_cmd_pkg::LEN_LSB +: 2]);
            acnt  <= 2'h0;
            if (b[i2c_cmd_pkg::BIT_DATA_ONLY]) begin
              if (is_mem(b[i2c_cmd_pkg::TGT_LSB +: 2]) && burst_byte_count != 16'h0000) begin
                // enter burst write, arm burst read
                burst_wr <= b[i2c_cmd_pkg::BIT_WRITE];
                burst_rd <= ~b[i2c_cmd_pkg::BIT_WRITE];
                rd_reg   <= 1'b0;
              end
            end else begin
              state <= S_ADDR;
            end
          end
          S_ADDR: begin
            if (tgt == i2c_cmd_pkg::TGT_REG) begin
              reg_addr <= b;
            end else begin
              addr <= next_addr;
            end
            if (!alen3 || acnt == i2c_cmd_pkg::ADDR_LAST) begin
              if (is_mem(tgt) && alen3) begin
                ptr_data <= tgt[0];
                ptr      <= wr ? next_addr : next_addr + 24'h000001;
                if (!wr) begin
                  mem_o <= '{req: 1'b1, we: 1'b0, data_mem: tgt[0], addr: next_addr, wdata: 8'h00};
                end
              end
              if (!wr) begin
                rd_reg   <= tgt == i2c_cmd_pkg::TGT_REG;
                burst_rd <= 1'b0;
              end
              state <= (wr && dleft != 3'h0) ? S_DATA : S_CMD;
            end else begin
              acnt <= acnt + 2'h1;
            end
          end
          S_DATA: begin
            if (is_mem(tgt)) begin
              mem_o <= '{req: 1'b1, we: 1'b1, data_mem: ptr_data, addr: ptr, wdata: b};
              ptr   <= ptr + 24'h000001;
            end else if (tgt == i2c_cmd_pkg::TGT_REG) begin
              case (reg_addr)
                i2c_cmd_pkg::REG_COUNT_LO: burst_byte_count[7:0]  <= b;
                i2c_cmd_pkg::REG_COUNT_HI: burst_byte_count[15:8] <= b;
                i2c_cmd_pkg::REG_DL_SETUP: download_setup         <= b;
                i2c_cmd_pkg::REG_HOST_SEL: host_port_select       <= b;
                default: ;
              endcase
              reg_addr <= reg_addr + 8'h01;
            end
            dleft <= dleft - 3'h1;
            if (dleft == 3'h1) begin
              state <= S_CMD;
            end
          end
          S_BURST_W: begin
            mem_o            <= '{req: 1'b1, we: 1'b1, data_mem: ptr_data, addr: ptr, wdata: b};
            ptr              <= ptr + 24'h000001;
            burst_byte_count <= burst_byte_count - 16'h0001;
            if (burst_byte_count == 16'h0001) begin
              burst_wr <= 1'b0;
              state    <= S_CMD;
            end
          end
          default: begin
            state <= S_CMD;
          end
        endcase
      end else if (evt.tx_next) begin
        if (!rd_reg) begin
          mem_o <= '{req: 1'b1, we: 1'b0, data_mem: ptr_data, addr: ptr, wdata: 8'h00};
          ptr   <= ptr + 24'h000001;
        end
        if (burst_rd) begin
          burst_byte_count <= burst_byte_count - 16'h0001;
          if (burst_byte_count == 16'h0001) begin
            burst_rd <= 1'b0;
          end
        end
      end
    end
  end

  // Transmit byte is ready long before the next SCL fall at 400 kbps
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_pend <= 1'b0;
      tx_byte    <= 8'h00;
    end else begin
      fetch_pend <= mem_o.req && !mem_o.we;
      if (fetch_pend) begin
        tx_byte <= mem_rdata_i;
      end else if (rd_reg) begin
        tx_byte <= reg_value(reg_addr, burst_byte_count, download_setup, host_port_select);
      end
    end
  end

  a_decode_target: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_CMD && !b[7] |=> tgt == $past(b[6:5]) && state == S_ADDR)
    else $error("Command target not decoded");
  a_setup_burst: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_CMD && b == 8'hA8 && burst_byte_count != 16'h0000 |=> burst_wr && !burst_rd)
    else $error("Write setup did not enter burst");
  a_arm_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_CMD && (b == 8'hA0 || b == 8'h80) && burst_byte_count != 16'h0000
    |=> burst_rd && !burst_wr)
    else $error("Read setup did not arm burst");
  a_no_reg_burst: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_CMD && b[7] && b[6:5] == 2'h2 |=> $stable(burst_wr) && $stable(burst_rd))
    else $error("Register target entered burst");
  a_burst_store: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_BURST_W |=> mem_o.req && mem_o.we && mem_o.addr == $past(ptr)
    && mem_o.wdata == $past(b) && ptr == $past(ptr) + 24'h000001)
    else $error("Burst byte not stored in order");
  a_count_exit: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_BURST_W && burst_byte_count == 16'h0001
    |=> burst_byte_count == 16'h0000 && !burst_wr && state == S_CMD)
    else $error("Burst did not end at zero count");
  a_seed_address: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.rx_valid && state == S_ADDR && alen3 && acnt == 2'h2 && wr && is_mem(tgt)
    |=> ptr == {$past(b), $past(addr[23:8])})
    else $error("Seed address assembled wrongly");
  a_read_ascend: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt.tx_next && !rd_reg |=> mem_o.req && !mem_o.we && mem_o.addr == $past(ptr) ##1 fetch_pend ##1
    tx_byte == $past(mem_rdata_i))
    else $error("Read data not fetched in order");
endmodule

//--- rtl/i2c_slave_link.sv
/*
  Byte-level I2C slave engine: start/stop detection, address match, ACK,
  byte receive and byte transmit. Assumes SCL and SDA are asynchronous pins.
*/
`timescale 1ns/10ps
module i2c_slave_link (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  input  wire logic [7:0]             tx_data_i,
  output i2c_cmd_pkg::link_evt_t      evt_o,
  output logic                        sda_o,
  output logic                        sda_oe_n_o
);
  typedef enum {L_IDLE, L_RX, L_ACK, L_TX, L_TXACK} link_state_t;
  link_state_t state;
  logic       scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       is_addr, rd, mack;
  logic       scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;
  // Open drain: the pin is only ever pulled low
  assign sda_o    = 1'b0;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state      <= L_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      is_addr    <= 1'b0;
      rd         <= 1'b0;
      mack       <= 1'b0;
      sda_oe_n_o <= 1'b1;
      evt_o      <= '0;
    end else begin
      evt_o <= '0;
      if (start_c) begin
        state       <= L_RX;
        cnt         <= 4'h0;
        is_addr     <= 1'b1;
        sda_oe_n_o  <= 1'b1;
        evt_o.start <= 1'b1;
      end else if (stop_c) begin
        state      <= L_IDLE;
        sda_oe_n_o <= 1'b1;
        evt_o.stop <= 1'b1;
      end else begin
        case (state)
          L_RX: begin
            if (scl_rise) begin
              sh  <= {sh[6:0], sda_s2};
              cnt <= cnt + 4'h1;
            end
            if (scl_fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              if (is_addr) begin
                if (sh[7:1] == i2c_cmd_pkg::DEV_ADDR7) begin
                  sda_oe_n_o   <= 1'b0;
                  rd           <= sh[0];
                  evt_o.addr_w <= ~sh[0];
                  state        <= L_ACK;
                end else begin
                  state <= L_IDLE;
                end
              end else begin
                sda_oe_n_o     <= 1'b0;
                evt_o.rx_valid <= 1'b1;
                evt_o.rx_data  <= sh;
                state          <= L_ACK;
              end
            end
          end
          L_ACK: begin
            if (scl_fall) begin
              is_addr <= 1'b0;
              if (rd) begin
                sh            <= tx_data_i;
                sda_oe_n_o    <= tx_data_i[7];
                evt_o.tx_next <= 1'b1;
                state         <= L_TX;
              end else begin
                sda_oe_n_o <= 1'b1;
                state      <= L_RX;
              end
            end
          end
          L_TX: begin
            if (scl_fall) begin
              sh  <= {sh[6:0], 1'b0};
              cnt <= cnt + 4'h1;
              if (cnt == 4'h7) begin
                sda_oe_n_o <= 1'b1;
                cnt        <= 4'h0;
                state      <= L_TXACK;
              end else begin
                sda_oe_n_o <= sh[6];
              end
            end
          end
          L_TXACK: begin
            if (scl_rise) begin
              mack <= ~sda_s2;
            end
            // A master NACK ends the read; the engine waits for stop
            if (scl_fall) begin
              if (mack) begin
                sh            <= tx_data_i;
                sda_oe_n_o    <= tx_data_i[7];
                evt_o.tx_next <= 1'b1;
                state         <= L_TX;
              end else begin
                state <= L_IDLE;
              end
            end
          end
          default: begin
            state <= L_IDLE;
          end
        endcase
      end
    end
  end

  a_ack_after_byte: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    evt_o.rx_valid |-> !sda_oe_n_o && state == L_ACK)
    else $error("Received byte not acknowledged");
endmodule

//--- testbench/i2c_host_command_burst_port_tb_top.sv
/*
  Self-checking bench: register access and bursts over I2C.
  Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/10ps
module i2c_host_command_burst_port_tb_top;
  typedef logic [7:0] byte_q_t[$];
  logic                  clk_sys_i;
  logic                  reset_n_i;
  logic                  scl_i;
  logic                  sda_i;
  logic                  sda_o;
  logic                  sda_oe_n_o;
  logic                  burst_active_o;
  logic                  host_scl;
  logic                  host_rel;
  logic                  nack;
  logic [7:0]            mem_rdata_i;
  logic [7:0]            host_port_select_o;
  logic [7:0]            download_setup_o;
  i2c_cmd_pkg::mem_req_t mem_o;
  logic [7:0]            dmem[logic [23:0]];
  logic [7:0]            imem[logic [23:0]];
  int                    n_mismatch = 0;
  int                    check_count = 0;
  wire                   sda_line = host_rel & (sda_oe_n_o | sda_o);

  i2c_host_command_burst_port u_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .host_port_select_o(host_port_select_o), .download_setup_o(download_setup_o),
    .burst_active_o(burst_active_o));

  i2c_host_model u_host (.scl_o(host_scl), .sda_rel_o(host_rel), .sda_i(sda_line));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Unwritten bytes hold a pattern derived from the address
  function automatic logic [7:0] rd_val(input logic dm, input logic [23:0] a);
    if (dm && dmem.exists(a)) return dmem[a];
    if (!dm && imem.exists(a)) return imem[a];
    return a[7:0] ^ (dm ? 8'h3C : 8'hA5);
  endfunction

  // Read data toggles outside its valid cycle so stale data is never trusted
  always @(posedge clk_sys_i) begin
    scl_i <= host_scl;
    sda_i <= sda_line;
    if (mem_o.req && mem_o.we && mem_o.data_mem) dmem[mem_o.addr] = mem_o.wdata;
    if (mem_o.req && mem_o.we && !mem_o.data_mem) imem[mem_o.addr] = mem_o.wdata;
    mem_rdata_i <= (mem_o.req && !mem_o.we) ? rd_val(mem_o.data_mem, mem_o.addr) : ~mem_rdata_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic send(input byte_q_t q);
    logic n;
    u_host.start_cond();
    foreach (q[i]) begin
      u_host.wbyte(q[i], n);
      check({7'h00, n}, 8'h00);
    end
    u_host.stop_cond();
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic read_frame(input byte_q_t exp);
    logic       n;
    logic [7:0] b;
    u_host.start_cond();
    u_host.wbyte(8'hE3, n);
    check({7'h00, n}, 8'h00);
    foreach (exp[i]) begin
      u_host.rbyte(i == exp.size() - 1, b);
      check(b, exp[i]);
    end
    u_host.stop_cond();
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic burst(input logic dm, input logic wr, input logic [23:0] a);
    byte_q_t q;
    int      sn;
    sn = wr ? (dm ? 2 : 4) : 0;
    send('{8'hE2, 8'h4A, 8'h08, 8'h04, 8'h00});
    q = '{8'hE2, wr ? (dm ? 8'h2B : 8'h0D) : (dm ? 8'h27 : 8'h07), a[7:0], a[15:8], a[23:16]};
    for (int i = 0; i < sn; i++) q.push_back(8'hC0 + 8'(i));
    send(q);
    send('{8'hE2, wr ? 8'hA8 : (dm ? 8'hA0 : 8'h80)});
    check({7'h00, burst_active_o}, 8'h01);
    if (wr) begin
      send('{8'hE2, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'h48, 8'h12, 8'h04});
      for (int i = 0; i < sn; i++) check(rd_val(dm, a + 24'(i)), 8'hC0 + 8'(i));
      for (int i = 0; i < 4; i++) check(rd_val(dm, a + 24'(sn + i)), 8'hD0 + 8'(i));
      check(host_port_select_o, 8'h04);
    end else begin
      q = {};
      for (int i = 0; i < 4; i++) q.push_back(rd_val(dm, a + 24'(i)));
      read_frame(q);
    end
    check({7'h00, burst_active_o}, 8'h00);
  endtask

  initial begin
    reset_n_i   = 1'b0;
    scl_i       = 1'b1;
    sda_i       = 1'b1;
    mem_rdata_i = 8'h00;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check(host_port_select_o, 8'h00);
    check({7'h00, sda_oe_n_o}, 8'h01);
    u_host.start_cond();
    u_host.wbyte(8'hE4, nack);
    check({7'h00, nack}, 8'h01);
    u_host.stop_cond();
    send('{8'hE2, 8'h48, 8'h0F, 8'h05});
    check(download_setup_o, 8'h05);
    burst(1'b1, 1'b1, 24'hFC603E);
    burst(1'b0, 1'b1, 24'h005340);
    burst(1'b1, 1'b0, 24'hFC6080);
    burst(1'b0, 1'b0, 24'h005380);
    // register target never arms a burst
    send('{8'hE2, 8'h4A, 8'h08, 8'h04, 8'h00});
    send('{8'hE2, 8'hC8});
    check({7'h00, burst_active_o}, 8'h00);
    send('{8'hE2, 8'h46, 8'h12});
    read_frame('{8'h04});
    give_verdict();
  end

  // About twelve thousand cycles are expected; five times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_mismatch++;
    give_verdict();
  end
endmodule

//--- testbench/i2c_host_model.sv
/*
  Behavioural I2C master standing in for the host processor.
  Assumes an open-drain wire with a pull-up resolved by the bench.
*/
`timescale 1ns/10ps
module i2c_host_model (
  output logic      scl_o,
  output logic      sda_rel_o,
  input  wire logic sda_i
);
  // SCL stands high between frames, 125 ns period inside them
  initial begin
    scl_o     = 1'b1;
    sda_rel_o = 1'b1;
  end

  // Data moves 21 ns after SCL falls, well clear of the synchroniser skew
  task automatic bit_io(input logic b, output logic s);
    #21 sda_rel_o = b;
    #42.5 scl_o = 1'b1;
    #30 s = sda_i;
    #31.5 scl_o = 1'b0;
  endtask

  task automatic start_cond();
    #20 sda_rel_o = 1'b1;
    #42.5 scl_o = 1'b1;
    #62.5 sda_rel_o = 1'b0;
    #62.5 scl_o = 1'b0;
  endtask

  // Edges stay off the core clock's rising edge so the bench sampler never races them
  task automatic stop_cond();
    #21 sda_rel_o = 1'b0;
    #42.5 scl_o = 1'b1;
    #62.5 sda_rel_o = 1'b1;
    #62.5;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, nack);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule
